// [hdl/fault_rec_regs.svh]
// Register offsets, field positions and timing counts of the fault recorder
`ifndef FAULT_REC_REGS_SVH
`define FAULT_REC_REGS_SVH
`define FR_DEPTH 20
`define FR_NMOD 8
`define FR_CLK_MHZ 20
// Time base of the duration counters, in microseconds
`define FR_TICK_US 1000
`define FR_TICK_CYC (`FR_TICK_US * `FR_CLK_MHZ)
`define FR_OFF_CTRL 32'h0000_0000
`define FR_OFF_DELAY 32'h0000_0004
`define FR_OFF_STATUS 32'h0000_0008
`define FR_OFF_SEL 32'h0000_000c
`define FR_OFF_REC0 32'h0000_0010
`define FR_OFF_REC1 32'h0000_0014
`define FR_OFF_REC2 32'h0000_0018
`define FR_OFF_REC3 32'h0000_001c
`define FR_OFF_KEYS 32'h0000_0020
`define FR_OFF_CFGVER 32'h0000_0024
`define FR_CTRL_MODE 0
`define FR_CTRL_AR 1
`define FR_CTRL_ADAPT 2
`define FR_KEY_ACK 0
`define FR_KEY_CLR 1
`define FR_KEY_RESTART 2
`endif

// [hdl/fault_rec_pkg.sv]
// Types shared by the fault recorder
package fault_rec_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPEN = 3'b010,
        ST_WAIT = 3'b100
    } rec_state_e;

    typedef struct packed {
        logic [7:0] fault_no;
        logic [7:0] grid_no;
        logic [2:0] first_pick;
        logic [2:0] first_trip;
        logic tripped;
        logic ttt_valid;
        logic [1:0] param_set;
        logic [1:0] adapt_set;
        logic [15:0] duration;
        logic [15:0] time_to_trip;
        logic [31:0] date_time;
        logic [15:0] meas;
        logic [7:0] cfg_ver;
    } record_s;

    typedef struct packed {
        logic [7:0] pickup;
        logic [7:0] trip;
    } prot_s;
endpackage : fault_rec_pkg

// [hdl/fault_event_recorder.sv]
// Fault recorder with twenty-entry record store and AHB-Lite registers
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`include "fault_rec_regs.svh"

module fault_event_recorder (
    input wire logic hclk, // Evaluation clock
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write strobe
    input wire logic [2:0] hsize, // Transfer size
    input wire logic hready, // Bus ready in
    input wire logic [31:0] hwdata, // Write data
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    input wire fault_rec_pkg::prot_s prot, // Pickups and trips per module
    input wire logic [15:0] meas_in, // Live measurement value
    input wire logic [31:0] date_time, // Real-time clock stamp
    input wire logic [1:0] param_set, // Active parameter set
    input wire logic [1:0] adapt_set, // Active adaptive set
    input wire logic auto_reclose, // Auto-reclose sequence running
    input wire logic [7:0] cfg_ver, // Configuration change count
    output logic popup, // Notification shown on display
    output logic [4:0] popup_idx, // Slot of the newest record
    output logic [7:0] safe_fault_no, // Fail-safe copy: fault number
    output logic safe_tripped // Fail-safe copy: trip flag
);
    import fault_rec_pkg::*;

    // ********************************
    // Input synchronisers and edges
    // ********************************
    prot_s prot_m_q, prot_s_q;
    logic ar_m_q, ar_s_q;
    logic pick_q, trip_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prot_m_q <= '0;
            prot_s_q <= '0;
            ar_m_q <= 1'b0;
            ar_s_q <= 1'b0;
        end else begin
            prot_m_q <= prot;
            prot_s_q <= prot_m_q;
            ar_m_q <= auto_reclose;
            ar_s_q <= ar_m_q;
        end
    end

    wire logic pick_any = |prot_s_q.pickup;
    wire logic trip_any = |prot_s_q.trip;
    wire logic pick_rise = pick_any && !pick_q;
    wire logic pick_fall = !pick_any && pick_q;
    wire logic trip_rise = trip_any && !trip_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pick_q <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            pick_q <= pick_any;
            trip_q <= trip_any;
        end
    end

    // Lowest-numbered active module wins a tie
    function automatic logic [2:0] first_set(input logic [7:0] v);
        first_set = 3'h0;
        for (int i = `FR_NMOD - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction : first_set

    // ********************************
    // Register bus
    // ********************************
    logic mode_alarms_q, ar_en_q, adapt_en_q;
    logic [15:0] delay_q;
    logic [4:0] sel_q;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic [31:0] rd_data_d;
    logic [2:0] key_pulse;

    wire logic bus_go = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0;
        end else begin
            wr_pend_q <= bus_go && hwrite;
            wr_addr_q <= haddr;
        end
    end

    wire logic wr_do = wr_pend_q;
    assign key_pulse = (wr_do && wr_addr_q == `FR_OFF_KEYS) ?
        hwdata[2:0] : 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_alarms_q <= 1'b1;
            ar_en_q <= 1'b0;
            adapt_en_q <= 1'b0;
            delay_q <= 16'h0;
            sel_q <= 5'h0;
        end else if (wr_do) begin
            if (wr_addr_q == `FR_OFF_CTRL) begin
                mode_alarms_q <= hwdata[`FR_CTRL_MODE];
                ar_en_q <= hwdata[`FR_CTRL_AR];
                adapt_en_q <= hwdata[`FR_CTRL_ADAPT];
            end
            if (wr_addr_q == `FR_OFF_DELAY) begin
                delay_q <= hwdata[15:0];
            end
            if (wr_addr_q == `FR_OFF_SEL) begin
                sel_q <= hwdata[4:0];
            end
        end
    end

    // ********************************
    // Recording engine
    // ********************************
    record_s mem [0:`FR_DEPTH-1];
    record_s cur_q;
    rec_state_e state_q;
    logic [7:0] fault_no_q, grid_no_q;
    logic in_ar_q;
    logic [4:0] wptr_q;
    logic [4:0] count_q;
    logic [14:0] tick_q;
    logic [15:0] dly_cnt_q;
    logic cap_pend_q;
    logic store_now;
    logic [31:0] ver_chk;

    wire logic tick = (tick_q == 15'(`FR_TICK_CYC - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 15'h0;
        end else begin
            tick_q <= tick ? 15'h0 : tick_q + 15'h1;
        end
    end

    // Record closes on the pickup fall; trips-only drops untripped ones
    assign store_now = (state_q == ST_OPEN) && pick_fall &&
        (mode_alarms_q || cur_q.tripped);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (pick_rise) begin
                        state_q <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (pick_fall) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_no_q <= 8'h0;
            grid_no_q <= 8'h0;
            in_ar_q <= 1'b0;
        end else if (pick_rise && state_q == ST_IDLE) begin
            fault_no_q <= fault_no_q + 8'h1;
            // Pickups during a reclose cycle share one grid number
            if (!(ar_en_q && in_ar_q)) begin
                grid_no_q <= grid_no_q + 8'h1;
            end
            in_ar_q <= ar_s_q;
        end else begin
            in_ar_q <= in_ar_q | ar_s_q;
            if (!ar_s_q && state_q == ST_IDLE) begin
                in_ar_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_q <= '0;
            cap_pend_q <= 1'b0;
            dly_cnt_q <= 16'h0;
        end else if (pick_rise && state_q == ST_IDLE) begin
            cur_q <= '0;
            cur_q.fault_no <= fault_no_q + 8'h1;
            cur_q.grid_no <= (ar_en_q && in_ar_q) ? grid_no_q :
                grid_no_q + 8'h1;
            cur_q.first_pick <= first_set(prot_s_q.pickup);
            cur_q.date_time <= date_time;
            cur_q.param_set <= param_set;
            cur_q.adapt_set <= adapt_en_q ? adapt_set : 2'h0;
            cur_q.cfg_ver <= cfg_ver;
            cap_pend_q <= 1'b0;
        end else if (state_q == ST_OPEN) begin
            if (tick && cur_q.duration != 16'hffff) begin
                cur_q.duration <= cur_q.duration + 16'h1;
                if (!cur_q.tripped) begin
                    cur_q.time_to_trip <= cur_q.time_to_trip + 16'h1;
                end
            end
            if (trip_rise && !cur_q.tripped) begin
                cur_q.tripped <= 1'b1;
                cur_q.first_trip <= first_set(prot_s_q.trip);
                cur_q.ttt_valid <= first_set(prot_s_q.trip) ==
                    cur_q.first_pick;
                if (first_set(prot_s_q.trip) != cur_q.first_pick) begin
                    cur_q.time_to_trip <= 16'h0;
                end
                if (delay_q == 16'h0) begin
                    cur_q.meas <= meas_in;
                end else begin
                    cap_pend_q <= 1'b1;
                    dly_cnt_q <= delay_q;
                end
            end else if (cap_pend_q && tick) begin
                if (dly_cnt_q == 16'h1) begin
                    cur_q.meas <= meas_in;
                    cap_pend_q <= 1'b0;
                end
                dly_cnt_q <= dly_cnt_q - 16'h1;
            end
            // A delayed capture cut short by the fall lands in cur_q after the store, so the stored record keeps meas at zero
            if (pick_fall && cap_pend_q) begin
                cur_q.meas <= meas_in;
                cap_pend_q <= 1'b0;
            end
            if (pick_fall && !cur_q.tripped) begin
                cur_q.time_to_trip <= 16'h0;
            end
        end
    end

    // Store in a ring; the write pointer runs over the oldest slot
    always_ff @(posedge hclk) begin
        if (store_now) begin
            mem[wptr_q] <= cur_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_q <= 5'h0;
            count_q <= 5'h0;
            popup_idx <= 5'h0;
            safe_fault_no <= 8'h0;
            safe_tripped <= 1'b0;
        end else if (store_now) begin
            wptr_q <= (wptr_q == 5'(`FR_DEPTH - 1)) ? 5'h0 :
                wptr_q + 5'h1;
            if (count_q != 5'(`FR_DEPTH)) begin
                count_q <= count_q + 5'h1;
            end
            popup_idx <= wptr_q;
            // Newest record mirrored to a retained copy
            safe_fault_no <= cur_q.fault_no;
            safe_tripped <= cur_q.tripped;
        end
    end

    // ********************************
    // Display notification
    // ********************************
    logic dismissed_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            popup <= 1'b0;
            dismissed_q <= 1'b0;
        end else if (pick_fall && state_q == ST_OPEN) begin
            // New fault shows even after an earlier dismissal
            popup <= store_now;
            dismissed_q <= !store_now;
        end else if (key_pulse[`FR_KEY_CLR]) begin
            popup <= 1'b0;
            dismissed_q <= 1'b1;
        end else if (key_pulse[`FR_KEY_ACK]) begin
            popup <= 1'b0;
        end else if (key_pulse[`FR_KEY_RESTART]) begin
            popup <= !dismissed_q && count_q != 5'h0;
        end
    end

    // ********************************
    // Read path
    // ********************************
    record_s view;
    assign view = mem[sel_q < 5'(`FR_DEPTH) ? sel_q : 5'h0];
    assign ver_chk = {31'h0, view.cfg_ver != cfg_ver};

    always_comb begin
        rd_data_d = 32'h0;
        unique case (haddr)
            `FR_OFF_CTRL: rd_data_d = {29'h0, adapt_en_q, ar_en_q,
                mode_alarms_q};
            `FR_OFF_DELAY: rd_data_d = {16'h0, delay_q};
            `FR_OFF_STATUS: rd_data_d = {11'h0, popup_idx, 3'h0, count_q,
                fault_no_q};
            `FR_OFF_SEL: rd_data_d = {27'h0, sel_q};
            `FR_OFF_REC0: rd_data_d = {view.fault_no, view.grid_no,
                view.first_pick, view.first_trip, view.tripped,
                view.ttt_valid, view.param_set, view.adapt_set,
                view.cfg_ver[3:0]};
            `FR_OFF_REC1: rd_data_d = {view.time_to_trip, view.duration};
            `FR_OFF_REC2: rd_data_d = view.date_time;
            `FR_OFF_REC3: rd_data_d = {16'h0, view.meas};
            `FR_OFF_CFGVER: rd_data_d = ver_chk;
            default: rd_data_d = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (bus_go && !hwrite) begin
                hrdata <= rd_data_d;
            end
        end
    end

    // ********************************
    // Checks
    // ********************************
    new_record_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_IDLE && pick_rise |=> state_q == ST_OPEN)
        else $error("pickup edge did not open a record");
    fault_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_IDLE && pick_rise |=>
        fault_no_q == $past(fault_no_q) + 8'h1)
        else $error("fault number not incremented");
    one_record_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_OPEN && pick_any |=> $stable(fault_no_q))
        else $error("second record while pickup held");
    drop_untrip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_OPEN && pick_fall && !mode_alarms_q &&
        !cur_q.tripped |=> $stable(count_q) && $stable(wptr_q))
        else $error("untripped record kept in trips-only mode");
    keep_alarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_OPEN && pick_fall && mode_alarms_q |=>
        wptr_q != $past(wptr_q))
        else $error("alarm record not stored");
    popup_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
        store_now |=> popup && popup_idx == $past(wptr_q))
        else $error("notification missing or not newest");
    ring_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        store_now && wptr_q == 5'(`FR_DEPTH - 1) |=> wptr_q == 5'h0)
        else $error("ring pointer did not wrap");
    trip_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == ST_OPEN && trip_rise && !cur_q.tripped &&
        delay_q == 16'h0 && !pick_fall |=>
        cur_q.meas == $past(meas_in) && cur_q.tripped)
        else $error("measurement not captured at trip");
    clear_key_a: assert property (@(posedge hclk) disable iff (!hresetn)
        key_pulse[`FR_KEY_CLR] && !(pick_fall && state_q == ST_OPEN) |=>
        !popup && dismissed_q)
        else $error("cleared notification came back");
endmodule : fault_event_recorder

// [verif/prot_model.sv]
// Behavioural protection modules driving pickup and trip levels
`timescale 1ns/100ps

module prot_model (
    input wire logic hclk, // Evaluation clock
    output fault_rec_pkg::prot_s prot // Pickups and trips per module
);
    import fault_rec_pkg::*;

    // ****************************************
    // Level driver
    // ****************************************
    initial begin
        prot = '0;
    end

    // Relay outputs are plain levels; they move just after an edge and
    // then stay put for n+1 cycles up to the next call, short or long as the caller wants
    task automatic drive(input logic [7:0] pk, input logic [7:0] tr,
                         input int n);
        @(posedge hclk);
        prot <= '{pickup: pk, trip: tr};
        repeat (n) @(posedge hclk);
    endtask : drive
endmodule : prot_model

// [verif/test_fault_event_recorder.sv]
// Self-checking bench for the fault recorder over its register bus
`timescale 1ns/100ps
`include "fault_rec_regs.svh"

module test_fault_event_recorder;
    import fault_rec_pkg::*;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic popup;
    logic safe_tripped;
    logic auto_reclose = 1'b0;
    logic [4:0] popup_idx;
    logic [7:0] safe_fault_no;
    logic [15:0] meas_in = 16'h0;
    logic [15:0] em = 16'h0;
    logic [7:0] cfg_ver = 8'h05;
    logic [31:0] rd;
    prot_s prot;
    int fails = 0;
    int compares = 0;
    int nf = 0;
    int ng = 0;
    int nrec = 0;

    always #25 hclk = ~hclk;

    prot_model u_prot (.hclk(hclk), .prot(prot));

    fault_event_recorder u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .prot(prot),
        .meas_in(meas_in), .date_time(32'h1234_5678), .param_set(2'h2),
        .adapt_set(2'h1), .auto_reclose(auto_reclose), .cfg_ver(cfg_ver),
        .popup(popup), .popup_idx(popup_idx),
        .safe_fault_no(safe_fault_no), .safe_tripped(safe_tripped)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    // Bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                fails++;
                $display("MISMATCH hready expected 1 seen stuck");
                summarize();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string w, input logic [31:0] a,
                       input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(w, e & m, rd & m);
    endtask : rdc

    // One pickup episode; the live value is changed after the trip so a
    // late capture shows up as the wrong value
    task automatic fault(input logic [7:0] pk, input logic [7:0] tr,
                         input logic keep, input logic g);
        nf++;
        ng += g;
        nrec += keep;
        em = 16'h0a00 + 16'(nf);
        u_prot.drive(pk, 8'h0, 6);
        meas_in <= em;
        u_prot.drive(pk, tr, 10);
        meas_in <= 16'hffff;
        u_prot.drive(8'h0, 8'h0, 10);
    endtask : fault

    task automatic chk_rec(input logic [2:0] fp, input logic [2:0] ft,
                           input logic trp, input logic tv);
        int s = (nrec - 1) % `FR_DEPTH;
        int c = (nrec > `FR_DEPTH) ? `FR_DEPTH : nrec;
        logic [31:0] e;
        logic [31:0] m;
        m = trp ? 32'hffff_fff0 : 32'hffff_e2f0;
        chk("popup", 32'h1, {31'h0, popup});
        chk("popup_idx", 32'(s), {27'h0, popup_idx});
        chk("safe_no", {24'h0, nf[7:0]}, {24'h0, safe_fault_no});
        chk("safe_trip", {31'h0, trp}, {31'h0, safe_tripped});
        e = {11'h0, s[4:0], 3'h0, c[4:0], 8'h0};
        rdc("status", `FR_OFF_STATUS, 32'h001f_1f00, e);
        wr(`FR_OFF_SEL, 32'(s));
        e = {nf[7:0], ng[7:0], fp, ft, trp, tv, 2'h2, 2'h1, 4'h0};
        rdc("rec0", `FR_OFF_REC0, m, e);
        rdc("date", `FR_OFF_REC2, 32'hffff_ffff, 32'h1234_5678);
        if (trp) begin
            rdc("meas", `FR_OFF_REC3, 32'h0000_ffff, {16'h0, em});
        end
        if (!tv) begin
            rdc("ttt", `FR_OFF_REC1, 32'hffff_0000, 32'h0);
        end
    endtask : chk_rec

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("popup", 32'h0, {31'h0, popup});
        rdc("ctrl", `FR_OFF_CTRL, 32'h1, 32'h1);
        rdc("status", `FR_OFF_STATUS, 32'h001f_1f00, 32'h0);
        rdc("unmapped", 32'h0000_0040, 32'hffff_ffff, 32'h0);
        wr(`FR_OFF_CTRL, 32'h7);
        $display("Test reset done");
        fault(8'h04, 8'h04, 1'b1, 1'b1);
        chk_rec(3'd2, 3'd2, 1'b1, 1'b1);
        $display("Test single fault done");
        nf++;
        ng++;
        nrec++;
        em = 16'h0b00;
        u_prot.drive(8'h02, 8'h0, 19999);
        meas_in <= em;
        u_prot.drive(8'h0a, 8'h08, 10);
        meas_in <= 16'hffff;
        u_prot.drive(8'h0, 8'h0, 10);
        chk_rec(3'd1, 3'd3, 1'b1, 1'b0);
        $display("Test two modules done");
        fault(8'h01, 8'h00, 1'b1, 1'b1);
        chk_rec(3'd0, 3'd0, 1'b0, 1'b0);
        wr(`FR_OFF_CTRL, 32'h6);
        fault(8'h01, 8'h00, 1'b0, 1'b1);
        chk("popup_idx", 32'h2, {27'h0, popup_idx});
        rdc("count", `FR_OFF_STATUS, 32'h1f00, 32'h0300);
        wr(`FR_OFF_CTRL, 32'h7);
        $display("Test record modes done");
        wr(`FR_OFF_DELAY, 32'h2);
        nf++;
        ng++;
        nrec++;
        em = 16'h0c0c;
        // Spans are whole tick periods, so the tick phase cannot move counts
        u_prot.drive(8'h10, 8'h0, 19999);
        meas_in <= 16'h0c00;
        u_prot.drive(8'h10, 8'h10, 100);
        meas_in <= em;
        u_prot.drive(8'h10, 8'h10, 39898);
        u_prot.drive(8'h0, 8'h0, 10);
        meas_in <= 16'hffff;
        wr(`FR_OFF_DELAY, 32'h0);
        chk_rec(3'd4, 3'd4, 1'b1, 1'b1);
        rdc("dur", `FR_OFF_REC1, 32'hffff_ffff, 32'h0001_0003);
        $display("Test capture delay done");
        rdc("cfg_chg", `FR_OFF_CFGVER, 32'h1, 32'h0);
        cfg_ver <= 8'h06;
        repeat (3) @(posedge hclk);
        rdc("cfg_chg", `FR_OFF_CFGVER, 32'h1, 32'h1);
        wr(`FR_OFF_KEYS, 32'h1);
        repeat (3) @(posedge hclk);
        chk("ack", 32'h0, {31'h0, popup});
        wr(`FR_OFF_KEYS, 32'h4);
        repeat (3) @(posedge hclk);
        chk("restart", 32'h1, {31'h0, popup});
        wr(`FR_OFF_KEYS, 32'h2);
        repeat (3) @(posedge hclk);
        chk("clear", 32'h0, {31'h0, popup});
        wr(`FR_OFF_KEYS, 32'h4);
        repeat (3) @(posedge hclk);
        chk("restart", 32'h0, {31'h0, popup});
        $display("Test keys done");
        auto_reclose <= 1'b1;
        repeat (6) @(posedge hclk);
        fault(8'h20, 8'h20, 1'b1, 1'b0);
        auto_reclose <= 1'b0;
        chk_rec(3'd5, 3'd5, 1'b1, 1'b1);
        $display("Test auto reclose done");
        for (int i = 0; i < 17; i++) begin
            fault(8'h80, 8'h80, 1'b1, 1'b1);
            chk_rec(3'd7, 3'd7, 1'b1, 1'b1);
        end
        $display("Test wrap done");
        summarize();
    end
endmodule : test_fault_event_recorder
